// ==== hdl/tpr_readout.sv ====
`timescale 1ns/1ns
// Behaviour
// (RULE1) format chosen by mode bits A12,A11
// (RULE2) strobes driven with every read burst
// (RULE3) serial: same pattern on every lane
// (RULE4) controller picks location on BA1:BA0
// (RULE5) x16 serial: all sixteen lanes identical
// (RULE6) parallel: bit 7 on lane 0, held
// (RULE7) parallel only from page zero
// (RULE8) x4 parallel: bits 7..4 on lanes
// (RULE9) x16 parallel: upper byte copies lower
// (RULE10) staggered only from page zero
// (RULE11) staggered lane k gets location n+k
// (RULE12) rotation starts at addressed location
// (RULE13) x8 staggered: upper nibble repeats lower
// (RULE14) x16 staggered: upper byte repeats lower
// (RULE15) back-to-back reads stream without gaps
// (RULE16) controller may cycle locations 0..3
// (RULE17) disallowed page data is undefined
module tpr_readout
    import tpr_pkg::*;
#(
    parameter int DQ_WIDTH = 8                  // device width: 4, 8 or 16
) (
    input  wire logic                clk,       // system clock
    input  wire logic                rst,       // synchronous reset, high
    input  wire logic                ui_clk,    // link unit-interval clock pin
    input  wire logic                rd_req,    // training read command pin
    input  wire logic [1:0]          rd_loc,    // BA1:BA0 location index pins
    input  wire logic [1:0]          rd_page,   // page selected for reads
    input  wire logic [1:0]          fmt_bits,  // mode_register_three A12:A11
    input  wire logic [31:0]         page_pat,  // selected page locations 3..0
    input  wire logic                wr_en,     // page zero write strobe
    input  wire logic [1:0]          wr_loc,    // page zero write location
    input  wire logic [7:0]          wr_data,   // page zero write data
    output logic [DQ_WIDTH-1:0]      dq_o,      // dq output values
    output logic                     dq_oe_n,   // dq output enable, low drives
    output logic                     dqs_o,     // strobe output value
    output logic                     dqs_oe_n,  // strobe output enable, low drives
    output logic                     fmt_err    // illegal page for format
);
    import tpr_pkg::*;

    // refuse device widths that the lane logic cannot serve
    if (DQ_WIDTH != 4 && DQ_WIDTH != 8 && DQ_WIDTH != 16) begin : g_width_check
        $error("tpr_readout: DQ_WIDTH must be 4, 8 or 16");
    end

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [SYNC_STAGES-1:0] uic_s_q;            // link clock sync chain
    logic [SYNC_STAGES-1:0] req_s_q;            // read command sync chain
    logic [1:0]             loc_s1_q, loc_s2_q; // location sync chain
    logic                   uic_prev_q;         // last synced link clock
    always_ff @(posedge clk) begin
        uic_s_q  <= {uic_s_q[0], ui_clk};
        req_s_q  <= {req_s_q[0], rd_req};
        loc_s1_q <= rd_loc;
        loc_s2_q <= loc_s1_q;
        uic_prev_q <= uic_s_q[1];
    end

    logic ui_tick;                              // one cycle per link rising edge
    assign ui_tick = uic_s_q[1] & ~uic_prev_q;

    // ------------------------------------------------------------------
    // page zero pattern store
    // ------------------------------------------------------------------
    logic [7:0] loc_q [NUM_LOC];                // page zero locations
    always_ff @(posedge clk) begin
        if (rst) begin
            loc_q[0] <= LOC0_RESET;
            loc_q[1] <= LOC1_RESET;
            loc_q[2] <= LOC2_RESET;
            loc_q[3] <= LOC3_RESET;
        end else if (wr_en) begin
            loc_q[wr_loc] <= wr_data;
        end
    end

    logic [31:0] p0_all;                        // page zero packed 3..0
    assign p0_all = {loc_q[3], loc_q[2], loc_q[1], loc_q[0]};

    // ------------------------------------------------------------------
    // command capture: a request is latched at a link edge
    // ------------------------------------------------------------------
    logic       pend_q;                         // next burst queued
    logic [1:0] pend_loc_q;                     // queued location
    logic       busy_q;                         // burst in progress
    logic [2:0] ui_q;                           // unit interval counter
    logic [1:0] cur_loc_q;                      // location of current burst
    logic [1:0] fmt_q;                          // format latched per burst
    logic [1:0] page_q;                         // page latched per burst
    logic [7:0] sel_q;                          // selected serial pattern
    logic       last_ui;                        // final interval of burst

    assign last_ui = busy_q && ui_q == 3'(BURST_UI - 1);

    // (RULE15) queue command so the next burst follows directly
    always_ff @(posedge clk) begin
        if (rst) begin
            pend_q     <= 1'b0;
            pend_loc_q <= 2'h0;
        end else if (ui_tick && req_s_q[1]) begin
            pend_q     <= 1'b1;
            pend_loc_q <= loc_s2_q;
        end else if (ui_tick && pend_q && (!busy_q || last_ui)) begin
            pend_q     <= 1'b0;
        end
    end

    // burst sequencer, one interval per link edge
    always_ff @(posedge clk) begin
        if (rst) begin
            busy_q    <= 1'b0;
            ui_q      <= 3'h0;
            cur_loc_q <= 2'h0;
            fmt_q     <= FMT_SERIAL;
            page_q    <= PAGE_ZERO;
            sel_q     <= 8'h00;
        end else if (ui_tick) begin
            if (pend_q && (!busy_q || last_ui)) begin
                // (RULE1) format taken from mode bits at burst start
                busy_q    <= 1'b1;
                ui_q      <= 3'h0;
                cur_loc_q <= pend_loc_q;
                fmt_q     <= {fmt_bits[FMT_A12_POS], fmt_bits[FMT_A11_POS]};
                page_q    <= rd_page;
                sel_q     <= (rd_page == PAGE_ZERO) ? loc_q[pend_loc_q] : page_pat[8*pend_loc_q +: 8];
            end else if (last_ui) begin
                busy_q <= 1'b0;
            end else if (busy_q) begin
                ui_q <= ui_q + 3'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // lane formatting
    // ------------------------------------------------------------------
    logic [DQ_WIDTH-1:0] lane_bits;             // combinational lane values
    // (RULE13) (RULE14) lanes modulo group reuse rotation; (RULE5) (RULE9) copies
    for (genvar k = 0; k < DQ_WIDTH; k++) begin : g_lane
        lane_mux #(.LANE(k % PAT_BITS)) u_lane (
            .fmt     (fmt_q),
            .ui      (ui_q),
            .loc     (cur_loc_q),
            .pat_sel (sel_q),
            .pat_all (p0_all),
            .bit_o   (lane_bits[k])
        );
    end

    // ------------------------------------------------------------------
    // registered pin outputs
    // ------------------------------------------------------------------
    // (RULE2) strobe toggles each interval alongside data
    always_ff @(posedge clk) begin
        if (rst) begin
            dq_o     <= '0;
            dq_oe_n  <= 1'b1;
            dqs_o    <= 1'b0;
            dqs_oe_n <= 1'b1;
        end else begin
            dq_o     <= busy_q ? lane_bits : '0;
            dq_oe_n  <= ~busy_q;
            dqs_o    <= busy_q ? ~ui_q[0] : 1'b0;
            dqs_oe_n <= ~busy_q;
        end
    end

    // (RULE7) (RULE10) flag parallel or staggered read of another page
    always_ff @(posedge clk) begin
        if (rst)
            fmt_err <= 1'b0;
        else
            fmt_err <= busy_q && fmt_q != FMT_SERIAL && page_q != PAGE_ZERO;
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_strobe_with_data; // (RULE2)
        @(posedge clk) disable iff (rst)
            busy_q |=> (dq_oe_n == 1'b0) && (dqs_oe_n == 1'b0) && (dqs_o == !$past(ui_q[0]));
    endproperty
    a_strobe_with_data: assert property (p_strobe_with_data) else $error("strobe not driven with data");

    property p_serial_same; // (RULE3)
        @(posedge clk) disable iff (rst)
            (busy_q && fmt_q == FMT_SERIAL) |=> (dq_o == {DQ_WIDTH{dq_o[0]}});
    endproperty
    a_serial_same: assert property (p_serial_same) else $error("serial lanes differ");

    property p_parallel_lane0; // (RULE6)
        @(posedge clk) disable iff (rst)
            (busy_q && fmt_q == FMT_PARALLEL) |=> (dq_o[0] == $past(sel_q[7]));
    endproperty
    a_parallel_lane0: assert property (p_parallel_lane0) else $error("parallel lane 0 not bit 7");

    property p_stagger_lane0; // (RULE12)
        @(posedge clk) disable iff (rst)
            (busy_q && fmt_q == FMT_STAGGERED && page_q == PAGE_ZERO)
            |=> (dq_o[0] == $past(sel_q[3'h7 - ui_q]));
    endproperty
    a_stagger_lane0: assert property (p_stagger_lane0) else $error("staggered lane 0 not addressed location");

    sequence s_burst_end;
        ui_tick && last_ui && pend_q;
    endsequence
    property p_no_gap; // (RULE15)
        @(posedge clk) disable iff (rst) s_burst_end |=> busy_q && ui_q == 3'h0;
    endproperty
    a_no_gap: assert property (p_no_gap) else $error("gap between back-to-back bursts");

    property p_page_err; // (RULE7)
        @(posedge clk) disable iff (rst)
            (busy_q && fmt_q == FMT_PARALLEL && page_q != PAGE_ZERO) |=> fmt_err;
    endproperty
    a_page_err: assert property (p_page_err) else $error("parallel page error not flagged");

    property p_stag_err; // (RULE10)
        @(posedge clk) disable iff (rst)
            (busy_q && fmt_q == FMT_STAGGERED && page_q != PAGE_ZERO) |=> fmt_err;
    endproperty
    a_stag_err: assert property (p_stag_err) else $error("staggered page error not flagged");

    property p_stag_lane1; // (RULE11)
        @(posedge clk) disable iff (rst)
            (busy_q && fmt_q == FMT_STAGGERED)
            |=> (dq_o[1] == $past(p0_all[8*2'(cur_loc_q + 2'h1) + (7 - ui_q)]));
    endproperty
    a_stag_lane1: assert property (p_stag_lane1) else $error("staggered lane 1 wrong location");

    property p_x4_upper; // (RULE8)
        @(posedge clk) disable iff (rst)
            (busy_q && fmt_q == FMT_PARALLEL) |=> (dq_o[3:0] == {$past(sel_q[4]), $past(sel_q[5]),
                                                                 $past(sel_q[6]), $past(sel_q[7])});
    endproperty
    a_x4_upper: assert property (p_x4_upper) else $error("parallel low lanes not bits 7..4");
endmodule

// ==== hdl/tpr_pkg.sv ====
package tpr_pkg;
    // ------------------------------------------------------------------
    // return formats selected by mode register three bits A12:A11
    // ------------------------------------------------------------------
    localparam logic [1:0] FMT_SERIAL    = 2'h0;    // same pattern on every lane
    localparam logic [1:0] FMT_PARALLEL  = 2'h1;    // pattern across lanes, held
    localparam logic [1:0] FMT_STAGGERED = 2'h2;    // rotated locations per lane
    localparam int         FMT_A12_POS   = 1;       // A12 position in format field
    localparam int         FMT_A11_POS   = 0;       // A11 position in format field
    // ------------------------------------------------------------------
    // burst and pattern geometry
    // ------------------------------------------------------------------
    localparam int         BURST_UI      = 8;       // unit intervals per read burst
    localparam int         PAT_BITS      = 8;       // bits per pattern location
    localparam int         NUM_LOC       = 4;       // locations per page
    localparam int         GROUP_LANES   = 4;       // lanes in a staggered group
    localparam logic [1:0] PAGE_ZERO     = 2'h0;    // only page allowed for par/stag
    // page-zero reset contents of locations 0..3
    localparam logic [7:0] LOC0_RESET    = 8'h55;
    localparam logic [7:0] LOC1_RESET    = 8'h33;
    localparam logic [7:0] LOC2_RESET    = 8'h0F;
    localparam logic [7:0] LOC3_RESET    = 8'h00;
    // ------------------------------------------------------------------
    // timing: system clock period and pin synchroniser depth
    // ------------------------------------------------------------------
    localparam int         CLK_PERIOD_NS = 20;      // 50 MHz system clock
    localparam int         SYNC_STAGES   = 2;       // pin synchroniser depth
endpackage

// ==== hdl/lane_mux.sv ====
`timescale 1ns/1ns
// picks the bit for one dq lane in the current unit interval
module lane_mux
    import tpr_pkg::*;
#(
    parameter int LANE = 0                      // lane number on the dq bus, modulo 8
) (
    input  wire logic [1:0]  fmt,               // active return format
    input  wire logic [2:0]  ui,                // unit interval within burst
    input  wire logic [1:0]  loc,               // addressed location
    input  wire logic [7:0]  pat_sel,           // selected page/location pattern
    input  wire logic [31:0] pat_all,           // page zero locations 3..0
    output logic             bit_o              // lane value for this interval
);
    // ------------------------------------------------------------------
    // lane bit selection
    // ------------------------------------------------------------------
    logic [1:0] rot;                            // rotated location for lane
    logic [7:0] rot_pat;                        // content of rotated location
    // (RULE12) rotation from addressed location
    always_comb begin
        rot     = 2'((int'(loc) + (LANE % GROUP_LANES)) % NUM_LOC);
        rot_pat = pat_all[8*rot +: 8];
        case (fmt)
            // (RULE3) serial, bit 7 first
            FMT_SERIAL:    bit_o = pat_sel[3'(PAT_BITS - 1) - ui];
            // (RULE6) (RULE8) parallel, bit 7 on lane 0, held
            FMT_PARALLEL:  bit_o = pat_sel[3'(PAT_BITS - 1 - (LANE % PAT_BITS))];
            // (RULE11) staggered rotated location serialised
            FMT_STAGGERED: bit_o = rot_pat[3'(PAT_BITS - 1) - ui];
            default:       bit_o = pat_sel[3'(PAT_BITS - 1) - ui];
        endcase
    end
endmodule

// ==== dv/tpr_ctrl_model.sv ====
`timescale 1ns/1ns
// controller side: makes the command clock and issues training reads
module tpr_ctrl_model (
    output logic       ui_clk,  // free-running command clock
    output logic       rd_req,  // read command level
    output logic [1:0] rd_loc   // location index
);
    // free-running clock, phase offset from the system clock
    initial begin
        ui_clk = 1'b0;
        #7;
        forever #80 ui_clk = ~ui_clk;
    end
    initial begin
        rd_req = 1'b0;
        rd_loc = 2'h0;
    end
    // n reads, one every eight intervals, locations rotating from start
    task automatic send(input logic [1:0] start, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge ui_clk);
            rd_req = 1'b1;
            rd_loc = start + 2'(i);
            @(negedge ui_clk);
            rd_req = 1'b0;
            // released index no longer shows the last value
            rd_loc = ~rd_loc;
            repeat (6) @(negedge ui_clk);
        end
    endtask
endmodule

// ==== dv/training_pattern_readout_format_tb.sv ====
`timescale 1ns/1ns
module training_pattern_readout_format_tb;
    import tpr_pkg::*;
    // ----------------
    // stimulus and taps
    // ----------------
    logic        clk, rst, ui_clk, rd_req, wr_en, cap, err_seen;   // controls
    logic [1:0]  rd_loc, rd_page, fmt_bits, wr_loc;                // command fields
    logic [7:0]  wr_data;                                          // page zero write
    logic [31:0] page_pat, pz;                                     // nonzero page, page zero image
    logic [15:0] dq16;                                             // x16 lanes
    logic [7:0]  dq8;                                              // x8 lanes
    logic [3:0]  dq4;                                              // x4 lanes
    logic        oe16, oe8, oe4, dqs16, dqs_oe16, err16;           // enables, strobe, error
    int          bad_count, tests_run, cycles;                     // score and timeout
    logic [31:0] q[$];                                             // captured intervals
    tpr_ctrl_model u_ctrl (.ui_clk(ui_clk), .rd_req(rd_req), .rd_loc(rd_loc));
    tpr_readout #(.DQ_WIDTH(16)) u_dut (.clk(clk), .rst(rst), .ui_clk(ui_clk), .rd_req(rd_req), .rd_loc(rd_loc),
        .rd_page(rd_page), .fmt_bits(fmt_bits), .page_pat(page_pat), .wr_en(wr_en), .wr_loc(wr_loc),
        .wr_data(wr_data), .dq_o(dq16), .dq_oe_n(oe16), .dqs_o(dqs16), .dqs_oe_n(dqs_oe16), .fmt_err(err16));
    tpr_readout #(.DQ_WIDTH(8)) u_dut8 (.clk(clk), .rst(rst), .ui_clk(ui_clk), .rd_req(rd_req), .rd_loc(rd_loc),
        .rd_page(rd_page), .fmt_bits(fmt_bits), .page_pat(page_pat), .wr_en(wr_en), .wr_loc(wr_loc),
        .wr_data(wr_data), .dq_o(dq8), .dq_oe_n(oe8), .dqs_o(), .dqs_oe_n(), .fmt_err());
    tpr_readout #(.DQ_WIDTH(4)) u_dut4 (.clk(clk), .rst(rst), .ui_clk(ui_clk), .rd_req(rd_req), .rd_loc(rd_loc),
        .rd_page(rd_page), .fmt_bits(fmt_bits), .page_pat(page_pat), .wr_en(wr_en), .wr_loc(wr_loc),
        .wr_data(wr_data), .dq_o(dq4), .dq_oe_n(oe4), .dqs_o(), .dqs_oe_n(), .fmt_err());
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // capture one word per interval; link edges never meet system edges
    always @(posedge ui_clk) begin
        if (cap && oe16 === 1'b0) begin
            q.push_back({dqs_oe16, dqs16, oe8, oe4, dq16, dq8, dq4});
        end
        if (cap && err16 === 1'b1) begin
            err_seen = 1'b1;
        end
    end
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // expected word of one interval for all three widths
    function automatic logic [31:0] exp_word(logic [1:0] fmt, logic [1:0] loc, int u, logic [31:0] src);
        logic [15:0] lanes;
        for (int k = 0; k < 16; k++) begin
            if (fmt == FMT_PARALLEL) lanes[k] = src[8 * loc + 7 - k % 8];
            else if (fmt == FMT_STAGGERED) lanes[k] = src[8 * ((loc + k) % 4) + 7 - u];
            else lanes[k] = src[8 * loc + 7 - u];
        end
        return {1'b0, u % 2 == 0, 2'b00, lanes, lanes[7:0], lanes[3:0]};
    endfunction
    // issue n reads, count the intervals and judge every one that comes back from a legal page
    task automatic run(input logic [1:0] fmt, input logic [1:0] page, input logic [1:0] start, input int n);
        logic [31:0] src;
        @(negedge clk);
        fmt_bits = fmt;
        rd_page = page;
        src = (page == PAGE_ZERO) ? pz : page_pat;
        q.delete();
        err_seen = 1'b0;
        cap = 1'b1;
        u_ctrl.send(start, n);
        repeat (4) @(posedge ui_clk);
        cap = 1'b0;
        check("burst_len", 32'(q.size()), 32'(8 * n));
        check("fmt_err", 32'(err_seen), 32'(fmt != FMT_SERIAL && page != PAGE_ZERO));
        // data of a refused page is undefined, so only legal pages are compared
        if (fmt == FMT_SERIAL || page == PAGE_ZERO) begin
            foreach (q[j]) check("dq_word", q[j], exp_word(fmt, start + 2'(j / 8), j % 8, src));
        end
    endtask
    task automatic t_reset();
        check("idle", 32'({oe16, dq16, err16, dqs_oe16}), 32'({1'b1, 16'h0, 1'b0, 1'b1}));
        $display("test reset done");
    endtask
    task automatic t_serial();
        run(FMT_SERIAL, 2'h0, 2'h2, 1);
        run(FMT_SERIAL, 2'h1, 2'h3, 1);
        run(2'h3, 2'h0, 2'h2, 1);
        @(negedge clk);
        wr_en = 1'b1;
        wr_loc = 2'h1;
        wr_data = 8'hA7;
        @(negedge clk);
        wr_en = 1'b0;
        pz[15:8] = 8'hA7;
        run(FMT_SERIAL, 2'h0, 2'h1, 1);
        $display("test serial done");
    endtask
    task automatic t_parallel();
        run(FMT_PARALLEL, 2'h0, 2'h0, 1);
        run(FMT_PARALLEL, 2'h0, 2'h1, 1);
        $display("test parallel done");
    endtask
    task automatic t_stagger();
        run(FMT_STAGGERED, 2'h0, 2'h0, 8);
        run(FMT_STAGGERED, 2'h0, 2'h3, 1);
        $display("test stagger done");
    endtask
    task automatic t_bad_page();
        run(FMT_PARALLEL, 2'h2, 2'h0, 1);
        run(FMT_STAGGERED, 2'h3, 2'h1, 1);
        $display("test bad page done");
    endtask
    initial begin
        rst = 1'b1;
        fmt_bits = FMT_SERIAL;
        rd_page = PAGE_ZERO;
        page_pat = 32'hC3A59612;
        pz = {LOC3_RESET, LOC2_RESET, LOC1_RESET, LOC0_RESET};
        wr_en = 1'b0;
        wr_loc = 2'h0;
        wr_data = 8'h00;
        cap = 1'b0;
        err_seen = 1'b0;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        t_reset();
        t_serial();
        t_parallel();
        t_stagger();
        t_bad_page();
        tally_and_finish();
    end
endmodule
